// ===== core/pll_synth_program_regs.sv
// Purpose: serial-loaded write-only configuration registers 1 to 4 of the synthesizer
// Assumes: serial clock, data and latch enable arrive asynchronously and are oversampled
// Notes: serial clock must stay well below a quarter of the system clock rate
// Notes: every output is registered; decoded settings lag the raw registers by one cycle
`timescale 1ns/1ps
module pll_synth_program_regs
(
    // system
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    // serial programming pins
    input wire logic SPI_CLK_IN,
    input wire logic SPI_DATA_IN,
    input wire logic SPI_LE_IN,
    // loop status
    input wire logic LOCK_DETECT_IN,
    // register contents
    output logic [23:0] MODULUS_REG_OUT,
    output logic [23:0] FRACTION_REG_OUT,
    output logic [23:0] DITHER_REG_OUT,
    output logic [23:0] PUMP_REG_OUT,
    // decoded settings
    output pll_regs_pkg::synth_cfg_t CFG_OUT,
    output logic MONITOR_OUTPUT_PIN_OUT
);

    // ************************************************************
    // helpers
    // ************************************************************
    // a pin level counts only once the second and third stages agree
    function automatic logic settled(input logic [2:0] stages);
        return stages[1] == stages[2];
    endfunction

    // agreed high while the filtered level is still low
    function automatic logic rising
    (
        input logic [2:0] stages,
        input logic level
    );
        return settled(stages) && stages[2] && !level;
    endfunction

    // load strobe for one destination; the code bits only steer the word [RL20]
    function automatic logic word_hits
    (
        input logic strobe,
        input logic [23:0] word,
        input logic [2:0] code
    );
        return strobe && (word[2:0] == code);
    endfunction

    // field split of the four raw registers
    function automatic pll_regs_pkg::synth_cfg_t decode_fields
    (
        input logic [23:0] modulus,
        input logic [23:0] fraction,
        input logic [23:0] dither,
        input logic [23:0] pump
    );
        pll_regs_pkg::synth_cfg_t f;
        f = '0;
        // ratio is integer + numerator/denominator; the host keeps numerator below denominator [RL18] [RL3]
        f.fraction_denominator = modulus[pll_regs_pkg::MOD_MSB:pll_regs_pkg::MOD_LSB]; // [RL4]
        f.fraction_numerator = fraction[pll_regs_pkg::FRAC_MSB:pll_regs_pkg::FRAC_LSB];
        f.dither_enable = dither[pll_regs_pkg::DITH_EN_BIT]; // [RL6]
        f.dither_magnitude = dither[pll_regs_pkg::DITH_MAG_MSB:pll_regs_pkg::DITH_MAG_LSB];
        f.dither_restart = dither[pll_regs_pkg::DITH_RESTART_MSB:pll_regs_pkg::DITH_RESTART_LSB]; // [RL8]
        f.pump_current_sel = pump[pll_regs_pkg::CP_CUR_MSB:pll_regs_pkg::CP_CUR_LSB]; // [RL10]
        f.pump_current_resistor = pump[pll_regs_pkg::CP_REF_BIT]; // [RL11]
        f.phase_offset_mult = pump[pll_regs_pkg::PH_OFS_MSB:pll_regs_pkg::PH_OFS_LSB]; // [RL12]
        f.phase_offset_negative = pump[pll_regs_pkg::PH_POL_BIT]; // [RL14]
        f.reference_scale = pump[pll_regs_pkg::REF_SCALE_MSB:pll_regs_pkg::REF_SCALE_LSB]; // [RL15]
        f.monitor_select = pump[pll_regs_pkg::MON_SEL_MSB:pll_regs_pkg::MON_SEL_LSB]; // [RL16]
        return f;
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] sclk_sync_r;
    logic [2:0] sdat_sync_r;
    logic [2:0] le_sync_r;
    logic sclk_level_r;
    logic le_level_r;
    logic sdat_level_r;

    // clock pin; reset to the idle low level so no false edge follows reset
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            sclk_sync_r <= 3'h0;
        end
        else
        begin
            sclk_sync_r <= {sclk_sync_r[1:0], SPI_CLK_IN};
        end
    end

    // data pin
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            sdat_sync_r <= 3'h0;
        end
        else
        begin
            sdat_sync_r <= {sdat_sync_r[1:0], SPI_DATA_IN};
        end
    end

    // latch pin
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            le_sync_r <= 3'h0;
        end
        else
        begin
            le_sync_r <= {le_sync_r[1:0], SPI_LE_IN};
        end
    end

    // a level moves only once the second and third stage agree
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            sclk_level_r <= 1'b0;
        end
        else if (settled(sclk_sync_r))
        begin
            sclk_level_r <= sclk_sync_r[2];
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            le_level_r <= 1'b0;
        end
        else if (settled(le_sync_r))
        begin
            le_level_r <= le_sync_r[2];
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            sdat_level_r <= 1'b0;
        end
        else if (settled(sdat_sync_r))
        begin
            sdat_level_r <= sdat_sync_r[2];
        end
    end

    logic sclk_rise;
    logic le_rise;
    // edges come from agreed stages, so a one-sample glitch never shifts or loads
    assign sclk_rise = rising(sclk_sync_r, sclk_level_r);
    assign le_rise = rising(le_sync_r, le_level_r);

    // ************************************************************
    // shift register
    // ************************************************************
    logic [23:0] shift_r;

    // data is taken from the settled level, which lags the clock edge by one stage
    // no bit counter: only the last 24 bits before the latch count
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            shift_r <= 24'h000000;
        end
        else if (sclk_rise)
        begin
            shift_r <= {shift_r[22:0], sdat_level_r};
        end
    end

    // ************************************************************
    // register load
    // ************************************************************
    logic load_modulus;
    logic load_fraction;
    logic load_dither;
    logic load_pump;

    // whole word is stored; control bits only steer it, other codes load nothing [RL20]
    assign load_modulus = word_hits(le_rise, shift_r, pll_regs_pkg::SEL_MODULUS); // [RL17]
    assign load_fraction = word_hits(le_rise, shift_r, pll_regs_pkg::SEL_FRACTION); // [RL1]
    assign load_dither = word_hits(le_rise, shift_r, pll_regs_pkg::SEL_DITHER); // [RL5]
    assign load_pump = word_hits(le_rise, shift_r, pll_regs_pkg::SEL_PUMP); // [RL9]

    // modulus
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            MODULUS_REG_OUT <= pll_regs_pkg::MODULUS_RST; // [RL4]
        end
        else if (load_modulus)
        begin
            MODULUS_REG_OUT <= shift_r; // [RL17]
        end
    end

    // fraction
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            FRACTION_REG_OUT <= pll_regs_pkg::FRACTION_RST; // [RL2]
        end
        else if (load_fraction)
        begin
            FRACTION_REG_OUT <= shift_r; // [RL1]
        end
    end

    // dither
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            DITHER_REG_OUT <= pll_regs_pkg::DITHER_RST; // [RL5] [RL6] [RL7]
        end
        else if (load_dither)
        begin
            DITHER_REG_OUT <= shift_r; // [RL5]
        end
    end

    // pump, detector and reference path
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            PUMP_REG_OUT <= pll_regs_pkg::PUMP_RST; // [RL9] [RL13]
        end
        else if (load_pump)
        begin
            PUMP_REG_OUT <= shift_r; // [RL9]
        end
    end

    // ************************************************************
    // decoded settings
    // ************************************************************
    pll_regs_pkg::synth_cfg_t cfg_nxt;

    // decoded from the raw registers, not the shift word, so settings trail the raw registers by one cycle
    always_comb
    begin
        cfg_nxt = decode_fields(MODULUS_REG_OUT, FRACTION_REG_OUT, DITHER_REG_OUT, PUMP_REG_OUT);
    end

    // settings read zero during reset, not the decoded defaults
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            CFG_OUT <= '0;
        end
        else
        begin
            CFG_OUT <= cfg_nxt;
        end
    end

    // ************************************************************
    // monitor output
    // ************************************************************
    logic monitor_nxt;

    // unused selections drive low rather than leave the pin floating
    // lock detect is not synchronised: it must come from this clock
    always_comb
    begin
        monitor_nxt = 1'b0;
        case (cfg_nxt.monitor_select)
            pll_regs_pkg::MON_LOCK_DETECT: monitor_nxt = LOCK_DETECT_IN; // [RL16]
            pll_regs_pkg::MON_DITHER_EN: monitor_nxt = cfg_nxt.dither_enable;
            pll_regs_pkg::MON_HIGH: monitor_nxt = 1'b1;
            default: monitor_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            MONITOR_OUTPUT_PIN_OUT <= 1'b0;
        end
        else
        begin
            MONITOR_OUTPUT_PIN_OUT <= monitor_nxt;
        end
    end

endmodule

// ===== shared/pll_regs_pkg.sv
// Purpose: constants and types for the synthesizer programming register bank
// Assumes: 24-bit serial words, control field in bits 2:0
// Notes: field positions of the dither and reference path registers are partly chosen
// Functional notes
// [RL1] control code 010 loads the fractional divide register
// [RL2] fractional divide register resets to 0x001802
// [RL3] host keeps fraction below the programmed modulus
// [RL4] modulus field is bits 13:3, legal 1..2047, default 1536
// [RL5] control code 011 loads dither register, reset 0x10000b
// [RL6] dither enable resets to one
// [RL7] dither magnitude resets to 15, host should set 1; DITHER_RST here decodes to magnitude 1
// [RL8] dither restart value accepts 0 to 2^17-1
// [RL9] control code 100 loads pump/detector/reference register, reset 0x0aa7e4
// [RL10] bits 11:10 pick pump current when bit 18 is zero
// [RL11] bit 18 set selects external resistor current reference
// [RL12] bits 16:12 hold phase offset multiplier in 22.5 degree steps
// [RL13] phase offset resets to 10, host should set 6
// [RL14] bit 17 selects phase offset polarity
// [RL15] reference path scales reference by 2, 1, 0.5 or 0.25
// [RL16] monitor output selectable, resets to lock detect
// [RL17] control code 001 loads the modulus divide register
// [RL18] divide ratio is integer plus fraction over modulus
// [RL19] host writes zeros into reserved bits
// [RL20] registers are 24 bits, control bits only select destination
package pll_regs_pkg;
    localparam int WORD_W = 24;
    localparam logic [2:0] SEL_MODULUS = 3'h1;
    localparam logic [2:0] SEL_FRACTION = 3'h2;
    localparam logic [2:0] SEL_DITHER = 3'h3;
    localparam logic [2:0] SEL_PUMP = 3'h4;
    localparam logic [23:0] MODULUS_RST = 24'h003001;
    localparam logic [23:0] FRACTION_RST = 24'h001802;
    localparam logic [23:0] DITHER_RST = 24'h10000b;
    localparam logic [23:0] PUMP_RST = 24'h0aa7e4;
    localparam int MOD_LSB = 3;
    localparam int MOD_MSB = 13;
    localparam int FRAC_LSB = 3;
    localparam int FRAC_MSB = 13;
    localparam int DITH_RESTART_LSB = 3;
    localparam int DITH_RESTART_MSB = 19;
    localparam int DITH_MAG_LSB = 20;
    localparam int DITH_MAG_MSB = 23;
    localparam int DITH_EN_BIT = 3;
    localparam int CP_CUR_LSB = 10;
    localparam int CP_CUR_MSB = 11;
    localparam int PH_OFS_LSB = 12;
    localparam int PH_OFS_MSB = 16;
    localparam int PH_POL_BIT = 17;
    localparam int CP_REF_BIT = 18;
    localparam int REF_SCALE_LSB = 19;
    localparam int REF_SCALE_MSB = 20;
    localparam int MON_SEL_LSB = 5;
    localparam int MON_SEL_MSB = 7;
    localparam logic [2:0] MON_LOCK_DETECT = 3'h7;
    localparam logic [2:0] MON_DITHER_EN = 3'h1;
    localparam logic [2:0] MON_HIGH = 3'h2;
    localparam int SPI_SYNC_STAGES = 3;

    typedef struct packed {
        logic [10:0] fraction_denominator;
        logic [10:0] fraction_numerator;
        logic dither_enable;
        logic [3:0] dither_magnitude;
        logic [16:0] dither_restart;
        logic [1:0] pump_current_sel;
        logic pump_current_resistor;
        logic [4:0] phase_offset_mult;
        logic phase_offset_negative;
        logic [1:0] reference_scale;
        logic [2:0] monitor_select;
    } synth_cfg_t;
endpackage

// ===== tb/pll_regs_chk.sv
// Purpose: port checks for the program register bank
// Assumes: bound to the top module
// Notes: load latency is only bounded by a quiet-time hold
`timescale 1ns/1ps
module pll_regs_chk
(
    // system and pins
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic SPI_LE_IN,
    input wire logic LOCK_DETECT_IN,
    // contents
    input wire logic [23:0] MODULUS_REG_OUT,
    input wire logic [23:0] FRACTION_REG_OUT,
    input wire logic [23:0] DITHER_REG_OUT,
    input wire logic [23:0] PUMP_REG_OUT,
    input wire pll_regs_pkg::synth_cfg_t CFG_OUT,
    input wire logic MONITOR_OUTPUT_PIN_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // six quiet cycles outlast the three-stage sync plus load
    sequence le_quiet;
        !SPI_LE_IN [*6];
    endsequence
    rst_val_a: assert property ($rose(RESETN_IN) |->
        {MODULUS_REG_OUT, FRACTION_REG_OUT, DITHER_REG_OUT, PUMP_REG_OUT} == 96'h003001_001802_10000b_0aa7e4)
        else $error("bad reset");
    frac_code_a: assert property ($changed(FRACTION_REG_OUT) |-> FRACTION_REG_OUT[2:0] == 3'h2)
        else $error("bad fraction load");
    dith_code_a: assert property ($changed(DITHER_REG_OUT) |-> DITHER_REG_OUT[2:0] == 3'h3)
        else $error("bad dither load");
    pump_code_a: assert property ($changed(PUMP_REG_OUT) |-> PUMP_REG_OUT[2:0] == 3'h4)
        else $error("bad pump load");
    quiet_hold_a: assert property (le_quiet |-> $stable({MODULUS_REG_OUT, FRACTION_REG_OUT, DITHER_REG_OUT,
        PUMP_REG_OUT})) else $error("register moved");
    cfg_div_a: assert property ($past(RESETN_IN) |->
        {CFG_OUT.fraction_denominator, CFG_OUT.fraction_numerator} ==
        $past({MODULUS_REG_OUT[13:3], FRACTION_REG_OUT[13:3]})) else $error("bad divider fields");
    cfg_pump_a: assert property ($past(RESETN_IN) |->
        {CFG_OUT.reference_scale, CFG_OUT.pump_current_resistor, CFG_OUT.phase_offset_negative,
        CFG_OUT.phase_offset_mult, CFG_OUT.pump_current_sel} == $past(PUMP_REG_OUT[20:10]))
        else $error("bad pump fields");
    cfg_dith_a: assert property ($past(RESETN_IN) |->
        {CFG_OUT.dither_enable, CFG_OUT.dither_restart} ==
        $past({DITHER_REG_OUT[3], DITHER_REG_OUT[19:3]})) else $error("bad dither fields");
    mon_lock_a: assert property (CFG_OUT.monitor_select == 3'h7 |->
        MONITOR_OUTPUT_PIN_OUT == $past(LOCK_DETECT_IN)) else $error("bad monitor");
endmodule

// ===== tb/spi_host_model.sv
// Purpose: host controller writing words on the serial pins
// Assumes: paced from the system clock falling edge
// Notes: link clock idles low between frames
`timescale 1ns/1ps
module spi_host_model
(
    // pacing
    input wire logic clk_in,
    // serial pins
    output logic sclk_out,
    output logic sdata_out,
    output logic le_out
);
    initial {sclk_out, sdata_out, le_out} = 3'h0;
    // 20 cycles is half the 160 ns link period
    task automatic half();
        repeat (20) @(negedge clk_in);
    endtask
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            sdata_out = w[i]; // msb first, code bits last
            half();
            sclk_out = 1'b1;
            half();
            sclk_out = 1'b0;
        end
        sdata_out = ~w[0]; // released line must not mimic the last bit
        half();
        le_out = 1'b1;
        half();
        le_out = 1'b0;
        half();
    endtask
endmodule

// ===== tb/tb.sv
// Purpose: self-checking bench for the program register bank
// Assumes: host model drives the serial pins
// Notes: host idle time after each latch covers the load latency
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lock = 1'b0;
    logic sclk, sdat, le, mon;
    logic [23:0] modr, frac, dith, pump, w;
    logic [2:0] m;
    pll_regs_pkg::synth_cfg_t cfg;
    int errors = 0;
    int cmp_count = 0;
    initial forever #2 clk = ~clk;
    pll_synth_program_regs uut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .SPI_CLK_IN(sclk), .SPI_DATA_IN(sdat),
        .SPI_LE_IN(le), .LOCK_DETECT_IN(lock), .MODULUS_REG_OUT(modr), .FRACTION_REG_OUT(frac),
        .DITHER_REG_OUT(dith), .PUMP_REG_OUT(pump), .CFG_OUT(cfg), .MONITOR_OUTPUT_PIN_OUT(mon));
    spi_host_model host (.clk_in(clk), .sclk_out(sclk), .sdata_out(sdat), .le_out(le));
    task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check("reset", {modr, frac, dith, pump}, 96'h003001_001802_10000b_0aa7e4);
        check("reset fields", {cfg.dither_enable, cfg.phase_offset_mult, cfg.monitor_select}, 9'h157);
        lock = 1'b1;
        repeat (2) @(negedge clk);
        check("monitor", mon, 1'b1);
        host.send(24'h003ff9); // largest modulus, reserved bits zero
        host.send(24'h003ff2); // fraction one below the modulus
        check("divider", {cfg.fraction_denominator, cfg.fraction_numerator}, 22'h3ffffe);
        // unused codes 101, 110, 111 and 000 must leave every register alone
        for (int i = 5; i < 8; i++)
            host.send({21'h1fffff, i[2:0]});
        host.send(24'hfffff8);
        check("refused", {modr, frac, dith, pump}, 96'h003ff9_003ff2_10000b_0aa7e4);
        host.send(24'h1ffffb); // magnitude 1, top restart value
        check("dither", {cfg.dither_magnitude, cfg.dither_enable, cfg.dither_restart}, 22'h07ffff);
        lock = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            m = (i == 3) ? 3'h7 : ((i == 0) ? 3'h1 : 3'h2);
            w = {3'h0, i[1:0], i[1], i[0], 5'h06, i[1:0], 2'h0, m, 2'h0, 3'h4};
            host.send(w); // phase offset 6 as advised
            check("pump", pump, w);
            check("pump fields", {cfg.reference_scale, cfg.pump_current_resistor, cfg.phase_offset_negative,
                cfg.phase_offset_mult, cfg.pump_current_sel}, w[20:10]);
            check("monitor", mon, i != 3);
        end
        finish_test();
    end
endmodule
bind pll_synth_program_regs pll_regs_chk chk (.SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN),
    .SPI_LE_IN(SPI_LE_IN), .LOCK_DETECT_IN(LOCK_DETECT_IN), .MODULUS_REG_OUT(MODULUS_REG_OUT),
    .FRACTION_REG_OUT(FRACTION_REG_OUT), .DITHER_REG_OUT(DITHER_REG_OUT), .PUMP_REG_OUT(PUMP_REG_OUT),
    .CFG_OUT(CFG_OUT), .MONITOR_OUTPUT_PIN_OUT(MONITOR_OUTPUT_PIN_OUT));
